// ### rtl/ovmc_map.vh
// Constants for the OTG VBUS monitor and control block.
// Assumes one inclusion per compile unit; the guard keeps a second one harmless.
`ifndef OVMC_MAP_VH
`define OVMC_MAP_VH

// ************************************************************
// Register byte offsets on the AXI4-Lite bus
// ************************************************************
`define OVMC_OFS_RISE_EN 5'h00
`define OVMC_OFS_FALL_EN 5'h04
`define OVMC_OFS_STATUS 5'h08
`define OVMC_OFS_LATCH 5'h0C
`define OVMC_OFS_OTG_CTRL 5'h10
`define OVMC_OFS_IFC_CTRL 5'h14
`define OVMC_OFS_MODE_CTRL 5'h18
`define OVMC_OFS_CHG_CTRL 5'h1C

// ************************************************************
// Event bit positions (enables, status, latch)
// ************************************************************
`define OVMC_EV_VBUS_VALID 1
`define OVMC_EV_SESS_VALID 2
`define OVMC_EV_SESS_END 3
`define OVMC_EV_DATA_SRC 5
`define OVMC_EV_MASK 8'h2E

// ************************************************************
// OTG control fields
// ************************************************************
`define OVMC_OTG_DISCHARGE 3
`define OVMC_OTG_CHARGE 4
`define OVMC_OTG_DRV 5
`define OVMC_OTG_DRV_EXT 6
`define OVMC_OTG_EXT_SEL 7

// ************************************************************
// Interface, mode and charger control fields
// ************************************************************
`define OVMC_IFC_COMPLEMENT 5
`define OVMC_IFC_PASSTHRU 6
`define OVMC_MODE_UART 0
`define OVMC_MODE_SUSPEND_N 1
`define OVMC_MODE_REG_LO 2
`define OVMC_MODE_REG_HI 3
`define OVMC_CHG_ENABLE 0

// ************************************************************
// Reset values and bus answers
// ************************************************************
`define OVMC_RST_EN 8'h00
`define OVMC_RST_OTG 8'h00
`define OVMC_RST_IFC 8'h00
`define OVMC_RST_MODE 8'h02
`define OVMC_RST_CHG 8'h00
`define OVMC_RESP_OKAY 2'h0
`define OVMC_RESP_SLVERR 2'h2

`endif

// ### rtl/ovmc_sync.v
// Two-stage synchroniser bank, one pair of flip-flops per bit.
// Assumes inputs are asynchronous levels; stage one is read only by stage two.
`timescale 1ns/1ps
`default_nettype none

module ovmc_sync #(
  parameter WIDTH = 4
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [WIDTH-1:0] d_async,
  output wire [WIDTH-1:0] q_sync
);

  // ************************************************************
  // Per-bit double flop
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_ff;
      reg sync_ff;
      // Constant reset keeps the chain clean of port values
      always @(posedge clk) begin
        if (rst) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else if (ce) begin
          meta_ff <= d_async[i];
          sync_ff <= meta_ff;
        end
      end
      assign q_sync[i] = sync_ff;
    end
  endgenerate

endmodule

`default_nettype wire

// ### rtl/ovmc_vbus_ctrl.v
// OTG VBUS monitor and control: comparator flags, receive commands,
// external indicator select, VBUS pulsing and supply enable, UART mode.
// Assumes analog comparator and line-state inputs are asynchronous, and a
// single AXI4-Lite master that respects the usual valid/ready handshake.
//
// Functional notes
// - Session-end flag rises when VBUS drops below the session-end threshold.
// - Session-end comparator off when both edge enables clear; status reads 0.
// - Session-valid readable in status; each change sends a receive command unless VBUS valid is reported.
// - Clearing session-valid enables stops interrupts only; commands still flow.
// - VBUS-valid comparator off when both enables clear; status bit 1 reads 0.
// - External VBUS indicator input is permanently tied to logic one.
// - External indicator logic is disabled after reset; internal comparator used.
// - Select/passthru/complement choose internal, fixed 1 or fixed 0 source.
// - Discharge resistor connected whenever OTG control bit 3 is set.
// - Charge resistor connected whenever OTG control bit 4 is set.
// - Supply-enable output is OR of both VBUS drive bits.
// - Both drive bits clear on reset; supply enable starts low.
// - UART mode selects UART regulator level and hides line state.
// - Charger detect works in low power; data-source status raises interrupts.
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ovmc_map.vh"

module ovmc_vbus_ctrl #(
  parameter [1:0] NORMAL_REG_LEVEL = 2'h0
) (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire CLK_EN,
  // AXI4-Lite slave
  input wire [4:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [4:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // Analog comparators and line state, asynchronous
  input wire COMP_SESSION_END,
  input wire COMP_SESSION_VALID,
  input wire COMP_VBUS_VALID,
  input wire COMP_DATA_SOURCE,
  input wire [1:0] LINE_STATE_IN,
  // Analog controls
  output wire COMP_SESSION_END_EN,
  output wire COMP_VBUS_VALID_EN,
  output wire VBUS_DISCHARGE_EN,
  output wire VBUS_CHARGE_EN,
  output wire VBUS_SUPPLY_ENABLE_OUT,
  output wire CHARGER_DETECT_EN,
  output wire [1:0] REGULATOR_LEVEL,
  output wire UART_MODE_ACTIVE,
  // Receive commands and interrupt toward the link
  output wire RXCMD_VALID,
  output wire [7:0] RXCMD_DATA,
  input wire RXCMD_READY,
  output wire LINK_INT
);

  // ************************************************************
  // Synchronised inputs
  // ************************************************************
  wire [5:0] sync_q;
  // All analog levels cross here before status, edges or commands
  ovmc_sync #(.WIDTH(6)) u_sync (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .ce(CLK_EN),
    .d_async({LINE_STATE_IN, COMP_DATA_SOURCE, COMP_VBUS_VALID, COMP_SESSION_VALID,
      COMP_SESSION_END}),
    .q_sync(sync_q)
  );

  wire session_end_raw = sync_q[0];
  wire session_valid_flag = sync_q[1];
  wire vbus_valid_raw = sync_q[2];
  wire data_source_raw = sync_q[3];
  wire [1:0] line_state = sync_q[5:4];

  // ************************************************************
  // Register storage
  // ************************************************************
  reg [7:0] rise_en_ff;
  reg [7:0] fall_en_ff;
  reg [7:0] latch_ff;
  reg [7:0] otg_ctrl_ff;
  reg [7:0] ifc_ctrl_ff;
  reg [7:0] mode_ctrl_ff;
  reg [7:0] chg_ctrl_ff;
  reg [7:0] prev_status_ff;

  wire [7:0] cmp_en = rise_en_ff | fall_en_ff;
  wire session_end_on = cmp_en[`OVMC_EV_SESS_END];
  wire vbus_valid_on = cmp_en[`OVMC_EV_VBUS_VALID];

  // Disabled comparators read back as zero
  wire session_end_flag = session_end_raw & session_end_on;
  wire vbus_valid_flag = vbus_valid_raw & vbus_valid_on;
  wire uart_mode = mode_ctrl_ff[`OVMC_MODE_UART];
  wire charger_on = chg_ctrl_ff[`OVMC_CHG_ENABLE];
  // Detect output only counts with both lines low; low power does not gate it
  wire data_source_detect = data_source_raw & charger_on & (line_state == 2'h0);

  // Status view; session-valid is never gated by its enables
  wire [7:0] status_now = {2'h0, data_source_detect, 1'b0, session_end_flag,
    session_valid_flag, vbus_valid_flag, 1'b0};

  // ************************************************************
  // External VBUS indicator select
  // ************************************************************
  wire ext_vbus_indicator = 1'b1;
  wire ext_vbus_indicator_select = otg_ctrl_ff[`OVMC_OTG_EXT_SEL];
  wire ind_q = ext_vbus_indicator ^ ifc_ctrl_ff[`OVMC_IFC_COMPLEMENT];
  // Passthru gives the indicator alone; otherwise it qualifies the comparator
  wire ind_src = ifc_ctrl_ff[`OVMC_IFC_PASSTHRU] ? ind_q : (vbus_valid_flag & ind_q);
  wire rx_vbus_valid = ext_vbus_indicator_select ? ind_src : vbus_valid_flag;

  // ************************************************************
  // Receive command encoding
  // ************************************************************
  reg [1:0] vbus_code;
  // Highest passed threshold wins
  always @* begin
    if (rx_vbus_valid) begin
      vbus_code = 2'h3;
    end else if (session_valid_flag) begin
      vbus_code = 2'h2;
    end else if (!session_end_flag) begin
      vbus_code = 2'h1;
    end else begin
      vbus_code = 2'h0;
    end
  end

  // Line state is not presented while in UART mode
  wire [1:0] rx_line = uart_mode ? 2'h0 : line_state;
  wire [7:0] rx_now = {4'h0, vbus_code, rx_line};

  reg [7:0] rx_prev_ff;
  reg rxcmd_valid_ff;
  reg [7:0] rxcmd_data_ff;
  wire rx_change = (rx_now != rx_prev_ff);

  // A new change overrides a pending command, so the link sees the latest state
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rx_prev_ff <= 8'h05;
      rxcmd_valid_ff <= 1'b0;
      rxcmd_data_ff <= 8'h00;
    end else if (CLK_EN) begin
      rx_prev_ff <= rx_now;
      if (rx_change) begin
        rxcmd_valid_ff <= 1'b1;
        rxcmd_data_ff <= rx_now;
      end else if (RXCMD_READY) begin
        rxcmd_valid_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Interrupt edges
  // ************************************************************
  wire [7:0] ev_rise = status_now & ~prev_status_ff & rise_en_ff & `OVMC_EV_MASK;
  wire [7:0] ev_fall = ~status_now & prev_status_ff & fall_en_ff & `OVMC_EV_MASK;
  wire [7:0] ev_set = ev_rise | ev_fall;

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  reg aw_held_ff;
  reg w_held_ff;
  reg [4:0] awaddr_ff;
  reg [7:0] wdata_ff;
  reg wstrb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;

  assign S_AXI_AWREADY = CLK_EN & ~aw_held_ff & ~bvalid_ff;
  assign S_AXI_WREADY = CLK_EN & ~w_held_ff & ~bvalid_ff;
  wire wr_go = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire wr_ok = (awaddr_ff[1:0] == 2'h0);
  wire wr_lane = wr_go & wr_ok & wstrb_ff;
  wire wr_rise = wr_lane & (awaddr_ff == `OVMC_OFS_RISE_EN);
  wire wr_fall = wr_lane & (awaddr_ff == `OVMC_OFS_FALL_EN);
  wire wr_latch = wr_lane & (awaddr_ff == `OVMC_OFS_LATCH);
  wire wr_otg = wr_lane & (awaddr_ff == `OVMC_OFS_OTG_CTRL);
  wire wr_ifc = wr_lane & (awaddr_ff == `OVMC_OFS_IFC_CTRL);
  wire wr_mode = wr_lane & (awaddr_ff == `OVMC_OFS_MODE_CTRL);
  wire wr_chg = wr_lane & (awaddr_ff == `OVMC_OFS_CHG_CTRL);

  // Address and data may come in either order; both are held until used
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 5'h00;
      wdata_ff <= 8'h00;
      wstrb_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `OVMC_RESP_OKAY;
    end else if (CLK_EN) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_ff <= 1'b1;
        wdata_ff <= S_AXI_WDATA[7:0];
        wstrb_ff <= S_AXI_WSTRB[0];
      end
      if (wr_go) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? `OVMC_RESP_OKAY : `OVMC_RESP_SLVERR;
      end else if (bvalid_ff && S_AXI_BREADY) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;

  // ************************************************************
  // Control registers and interrupt latch
  // ************************************************************
  // Reset clears both drive bits and the indicator select
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rise_en_ff <= `OVMC_RST_EN;
      fall_en_ff <= `OVMC_RST_EN;
      otg_ctrl_ff <= `OVMC_RST_OTG;
      ifc_ctrl_ff <= `OVMC_RST_IFC;
      mode_ctrl_ff <= `OVMC_RST_MODE;
      chg_ctrl_ff <= `OVMC_RST_CHG;
      latch_ff <= 8'h00;
      prev_status_ff <= 8'h00;
    end else if (CLK_EN) begin
      prev_status_ff <= status_now;
      if (wr_rise) begin
        rise_en_ff <= wdata_ff & `OVMC_EV_MASK;
      end
      if (wr_fall) begin
        fall_en_ff <= wdata_ff & `OVMC_EV_MASK;
      end
      if (wr_otg) begin
        otg_ctrl_ff <= wdata_ff;
      end
      if (wr_ifc) begin
        ifc_ctrl_ff <= wdata_ff & 8'h60;
      end
      if (wr_mode) begin
        mode_ctrl_ff <= wdata_ff & 8'h0F;
      end
      if (wr_chg) begin
        chg_ctrl_ff <= wdata_ff & 8'h01;
      end
      // Write one to clear; a same-cycle event still sets the bit
      latch_ff <= (latch_ff & ~(wr_latch ? wdata_ff : 8'h00)) | ev_set;
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  reg rvalid_ff;
  reg [7:0] rdata_ff;
  reg [1:0] rresp_ff;
  reg [7:0] rd_mux;
  reg rd_hit;

  assign S_AXI_ARREADY = CLK_EN & ~rvalid_ff;

  // Unmapped offsets answer zero with an error response
  always @* begin
    rd_hit = (S_AXI_ARADDR[1:0] == 2'h0);
    case (S_AXI_ARADDR)
      `OVMC_OFS_RISE_EN: rd_mux = rise_en_ff;
      `OVMC_OFS_FALL_EN: rd_mux = fall_en_ff;
      `OVMC_OFS_STATUS: rd_mux = status_now;
      `OVMC_OFS_LATCH: rd_mux = latch_ff;
      `OVMC_OFS_OTG_CTRL: rd_mux = otg_ctrl_ff;
      `OVMC_OFS_IFC_CTRL: rd_mux = ifc_ctrl_ff;
      `OVMC_OFS_MODE_CTRL: rd_mux = mode_ctrl_ff;
      `OVMC_OFS_CHG_CTRL: rd_mux = chg_ctrl_ff;
      default: begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 8'h00;
      rresp_ff <= `OVMC_RESP_OKAY;
    end else if (CLK_EN) begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_hit ? `OVMC_RESP_OKAY : `OVMC_RESP_SLVERR;
      end else if (rvalid_ff && S_AXI_RREADY) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA = {24'h000000, rdata_ff};
  assign S_AXI_RRESP = rresp_ff;

  // ************************************************************
  // Registered analog control outputs
  // ************************************************************
  reg supply_en_ff;
  reg [1:0] reg_level_ff;

  // Registered so the power switch never sees a decode glitch
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      supply_en_ff <= 1'b0;
      reg_level_ff <= NORMAL_REG_LEVEL;
    end else if (CLK_EN) begin
      supply_en_ff <= otg_ctrl_ff[`OVMC_OTG_DRV] | otg_ctrl_ff[`OVMC_OTG_DRV_EXT];
      reg_level_ff <= uart_mode ?
        mode_ctrl_ff[`OVMC_MODE_REG_HI:`OVMC_MODE_REG_LO] : NORMAL_REG_LEVEL;
    end
  end

  assign COMP_SESSION_END_EN = session_end_on;
  assign COMP_VBUS_VALID_EN = vbus_valid_on;
  assign VBUS_DISCHARGE_EN = otg_ctrl_ff[`OVMC_OTG_DISCHARGE];
  assign VBUS_CHARGE_EN = otg_ctrl_ff[`OVMC_OTG_CHARGE];
  assign VBUS_SUPPLY_ENABLE_OUT = supply_en_ff;
  assign CHARGER_DETECT_EN = charger_on;
  assign REGULATOR_LEVEL = reg_level_ff;
  assign UART_MODE_ACTIVE = uart_mode;
  assign RXCMD_VALID = rxcmd_valid_ff;
  assign RXCMD_DATA = rxcmd_data_ff;
  // Level interrupt holds in low power as well as synchronous mode
  assign LINK_INT = |latch_ff;

endmodule

`default_nettype wire

// ### rtl/ovmc_pad_note.v
// Intentionally minimal: no logic.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### verification/ovmc_vbus_ctrl_asserts.sv
// Port-level checker for the OTG VBUS monitor and control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module ovmc_vbus_ctrl_asserts (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic COMP_SESSION_END_EN,
  input wire logic VBUS_SUPPLY_ENABLE_OUT,
  input wire logic [1:0] REGULATOR_LEVEL,
  input wire logic UART_MODE_ACTIVE,
  input wire logic RXCMD_VALID,
  input wire logic [7:0] RXCMD_DATA,
  input wire logic RXCMD_READY
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);

  // ************************************************************
  // Bus handshake
  // ************************************************************
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
    && S_AXI_WREADY |-> ##2 S_AXI_BVALID) else $error("write answer not on time");
  a_write_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while answer pending");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer not on time");
  a_read_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY
    && S_AXI_RDATA[31:8] == 24'h000000) else $error("read overlap or upper data");

  // ************************************************************
  // Receive commands, supply and UART mode
  // ************************************************************
  // Only fresh commands are judged: a stalled one may predate the enable
  a_sess_end_off: assert property ($rose(RXCMD_VALID) && !COMP_SESSION_END_EN
    && $past(!COMP_SESSION_END_EN, 4) |-> RXCMD_DATA[3:2] != 2'h0)
    else $error("session end reported while disabled");
  a_rxcmd_holds: assert property (RXCMD_VALID && !RXCMD_READY |=> RXCMD_VALID)
    else $error("receive command dropped before acceptance");
  a_rxcmd_upper: assert property (RXCMD_VALID |-> RXCMD_DATA[7:4] == 4'h0)
    else $error("receive command upper bits set");
  a_supply_reset: assert property ($fell(SYS_RST) |-> !VBUS_SUPPLY_ENABLE_OUT)
    else $error("supply enable high after reset");
  a_uart_line_hidden: assert property ($rose(RXCMD_VALID) && UART_MODE_ACTIVE
    && $past(UART_MODE_ACTIVE, 3) |-> RXCMD_DATA[1:0] == 2'h0)
    else $error("line state shown in UART mode");
  a_normal_level: assert property (!UART_MODE_ACTIVE && $past(!UART_MODE_ACTIVE)
    |-> REGULATOR_LEVEL == 2'h0) else $error("regulator level wrong outside UART mode");

  c_rx_stall: cover property ($rose(RXCMD_VALID) && !RXCMD_READY);
  c_bus_error: cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
  c_uart_entry: cover property ($rose(UART_MODE_ACTIVE));
endmodule

bind ovmc_vbus_ctrl ovmc_vbus_ctrl_asserts u_asserts (.CLK_SYS, .SYS_RST,
  .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
  .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID,
  .COMP_SESSION_END_EN, .VBUS_SUPPLY_ENABLE_OUT, .REGULATOR_LEVEL, .UART_MODE_ACTIVE,
  .RXCMD_VALID, .RXCMD_DATA, .RXCMD_READY);

`default_nettype wire

// ### verification/ovmc_link_model.sv
// Link-side model that accepts receive commands, promptly or slowly.
// Assumes one clock shared with the block and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none

module ovmc_link_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic [7:0] last_rx,
  output logic [15:0] rx_count
);
  logic ready_ff;
  logic [7:0] last_ff;
  logic [15:0] count_ff;

  // Slow mode accepts every other cycle, so commands must stand
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_ff <= 1'h0;
      last_ff <= 8'h00;
      count_ff <= 16'h0000;
    end else begin
      ready_ff <= slow ? !ready_ff : 1'h1;
      if (rx_valid && ready_ff) begin
        last_ff <= rx_data;
        count_ff <= count_ff + 16'h0001;
      end
    end
  end
  assign rx_ready = ready_ff;
  assign last_rx = last_ff;
  assign rx_count = count_ff;
endmodule

`default_nettype wire

// ### verification/testbench.sv
// Bench for the OTG VBUS monitor and control block over AXI4-Lite.
// Assumes ovmc_map.vh on the include path and the link model compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ovmc_map.vh"

module testbench;
  localparam logic [1:0] OK = `OVMC_RESP_OKAY;
  localparam logic [1:0] ERR = `OVMC_RESP_SLVERR;
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [3:0] comp = 4'h0;
  logic [1:0] line = 2'h1;
  logic slow = 1'h0;
  logic [7:0] rst_val [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
  wire logic awready, wready, bvalid, arready, rvalid, se_en, dis, chg, sup, cd_en, uart;
  wire logic rxv, rxr, link_int, vb_en;
  wire logic [1:0] bresp, rresp, lvl;
  wire logic [31:0] rdata;
  wire logic [7:0] rxd, last_rx;
  wire logic [15:0] rx_count;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  ovmc_vbus_ctrl DUT (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CLK_EN(1'h1),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .COMP_SESSION_END(comp[0]), .COMP_SESSION_VALID(comp[1]), .COMP_VBUS_VALID(comp[2]),
    .COMP_DATA_SOURCE(comp[3]), .LINE_STATE_IN(line), .COMP_SESSION_END_EN(se_en),
    .COMP_VBUS_VALID_EN(vb_en), .VBUS_DISCHARGE_EN(dis), .VBUS_CHARGE_EN(chg),
    .VBUS_SUPPLY_ENABLE_OUT(sup), .CHARGER_DETECT_EN(cd_en), .REGULATOR_LEVEL(lvl),
    .UART_MODE_ACTIVE(uart), .RXCMD_VALID(rxv), .RXCMD_DATA(rxd), .RXCMD_READY(rxr),
    .LINK_INT(link_int));
  ovmc_link_model u_link (.clk(clk_sys), .rst(sys_rst), .slow(slow), .rx_valid(rxv),
    .rx_data(rxd), .rx_ready(rxr), .last_rx(last_rx), .rx_count(rx_count));

  // ************************************************************
  // Clock, hang guard and closing report
  // ************************************************************
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      results();
    end
  end
  task automatic results();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ************************************************************
  // Bus tasks and comparison
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Handshakes sampled mid-cycle, released just after the taking edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    logic [1:0] r;
    n = 0;
    tb = 1'h0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!tb && n < 50) begin
      @(negedge clk_sys);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk_sys);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      n++;
    end
    bready <= 1'h0;
    @(posedge clk_sys);
    chk(tb ? 32'(r) : 32'hFFFFFFFF, 32'(er));
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] ed, input logic [1:0] er);
    int n;
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    tr = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!tr && n < 50) begin
      @(negedge clk_sys);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ta) arvalid <= 1'h0;
      n++;
    end
    rready <= 1'h0;
    @(posedge clk_sys);
    chk(tr ? d : 32'hFFFFFFFF, {24'h000000, ed});
    chk(32'(r), 32'(er));
  endtask
  task automatic wait_rx();
    int n;
    logic [15:0] c;
    c = rx_count;
    n = 0;
    while (rx_count == c && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(rx_count != c), 32'h1);
  endtask

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    logic exp_v;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'h0;
    @(posedge clk_sys);
    for (int i = 0; i < 8; i++) rd(5'(i * 4), rst_val[i], OK);
    chk(32'({sup, lvl}), 32'h0);
    rd(5'h02, 8'h00, ERR);
    wr(5'h11, 8'hFF, ERR);
    wstrb <= 4'h0;
    wr(`OVMC_OFS_OTG_CTRL, 8'hFF, OK);
    wstrb <= 4'hF;
    rd(`OVMC_OFS_OTG_CTRL, 8'h00, OK);
    $display("test reset and bus done");
    for (int i = 0; i < 4; i++) begin
      wr(`OVMC_OFS_OTG_CTRL, {1'h0, 2'(i), 5'h18}, OK);
      idle(2);
      chk(32'({dis, chg, sup}), {29'h0, 2'h3, i != 0});
    end
    wr(`OVMC_OFS_OTG_CTRL, 8'h08, OK);
    chk(32'({dis, chg}), 32'h2);
    $display("test otg control done");
    comp[0] <= 1'h1;
    idle(6);
    rd(`OVMC_OFS_STATUS, 8'h00, OK);
    wr(`OVMC_OFS_FALL_EN, 8'h08, OK);
    chk(32'(se_en), 32'h1);
    wait_rx();
    chk(32'(last_rx), {28'h0, 2'h0, line});
    rd(`OVMC_OFS_STATUS, 8'h08, OK);
    wr(`OVMC_OFS_FALL_EN, 8'h00, OK);
    comp[0] <= 1'h0;
    wr(`OVMC_OFS_LATCH, 8'h2E, OK);
    $display("test session end done");
    slow <= 1'h1;
    comp[1] <= 1'h1;
    wait_rx();
    chk(32'(last_rx), {28'h0, 2'h2, line});
    rd(`OVMC_OFS_STATUS, 8'h04, OK);
    chk(32'(link_int), 32'h0);
    wr(`OVMC_OFS_RISE_EN, 8'h04, OK);
    comp[1] <= 1'h0;
    wait_rx();
    chk(32'({link_int, last_rx}), {23'h0, 1'h0, 4'h0, 2'h1, line});
    comp[1] <= 1'h1;
    idle(8);
    chk(32'(link_int), 32'h1);
    rd(`OVMC_OFS_LATCH, 8'h04, OK);
    wr(`OVMC_OFS_LATCH, 8'h04, OK);
    chk(32'(link_int), 32'h0);
    $display("test session valid done");
    comp[2] <= 1'h1;
    idle(6);
    rd(`OVMC_OFS_STATUS, 8'h04, OK);
    wr(`OVMC_OFS_RISE_EN, 8'h02, OK);
    chk(32'(vb_en), 32'h1);
    wait_rx();
    chk(32'(last_rx[3:2]), 32'h3);
    rd(`OVMC_OFS_STATUS, 8'h06, OK);
    for (int k = 0; k < 16; k++) begin
      comp[2] <= k[3];
      wr(`OVMC_OFS_IFC_CTRL, {1'h0, k[1], k[0], 5'h00}, OK);
      wr(`OVMC_OFS_OTG_CTRL, {k[2], 7'h00}, OK);
      idle(8);
      exp_v = k[2] ? (!k[0] && (k[1] || k[3])) : k[3];
      chk(32'(last_rx[3:2]), exp_v ? 32'h3 : 32'h2);
    end
    wr(`OVMC_OFS_OTG_CTRL, 8'h00, OK);
    wr(`OVMC_OFS_RISE_EN, 8'h00, OK);
    chk(32'(vb_en), 32'h0);
    wr(`OVMC_OFS_LATCH, 8'h2E, OK);
    $display("test vbus indicator done");
    slow <= 1'h0;
    line <= 2'h2;
    wr(`OVMC_OFS_MODE_CTRL, 8'h0B, OK);
    idle(8);
    chk(32'({uart, lvl}), 32'h6);
    comp[1] <= 1'h0;
    wait_rx();
    chk(32'(last_rx), 32'h04);
    wr(`OVMC_OFS_MODE_CTRL, 8'h02, OK);
    idle(2);
    chk(32'({uart, lvl}), 32'h0);
    $display("test uart done");
    line <= 2'h0;
    wr(`OVMC_OFS_CHG_CTRL, 8'h01, OK);
    wr(`OVMC_OFS_MODE_CTRL, 8'h00, OK);
    wr(`OVMC_OFS_RISE_EN, 8'h20, OK);
    comp[3] <= 1'h1;
    idle(8);
    chk(32'({cd_en, link_int}), 32'h3);
    rd(`OVMC_OFS_STATUS, 8'h20, OK);
    wr(`OVMC_OFS_LATCH, 8'h20, OK);
    wr(`OVMC_OFS_CHG_CTRL, 8'h00, OK);
    chk(32'({cd_en, link_int}), 32'h0);
    $display("test charger detect done");
    results();
  end
endmodule

`default_nettype wire
